// [acfs_pkg.sv]
// Shared constants and types of the conversion sequencer.
package acfs_pkg;
  localparam int DATA_W = 12;
  localparam int CH_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int IDX_W = 2;
  localparam int IRQ_W = 3;

  // Byte offsets of the register window.
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_FIFO = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_SINGLE = 8'h10;
  localparam logic [7:0] REG_IRQ_ST = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  // Command register fields.
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_CH_LSB = 4;

  // Interrupt status bit positions.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_THR = 1;
  localparam int IRQ_REFUSE = 2;

  // Status register bit positions.
  localparam int ST_CNT_LSB = 0;
  localparam int ST_HOLD = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_CHAN_OK = 6;
  localparam int ST_PD = 7;
  localparam int ST_SGL_VALID = 8;
  localparam int ST_IDX_LSB = 9;
  localparam int ST_CH_LSB = 12;

  // Conversion length in link clock rising edges.
  localparam logic [4:0] CONV_SCLKS = 5'h0E;
  // Reset configuration: single shot, threshold eight, one-entry sequence.
  localparam logic [23:0] CFG_RST = 24'h00001C;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_SWEEP = 2'b10,
    MODE_RSWEEP = 2'b11
  } acfs_mode_t;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_SELECT = 4'h1,
    CMD_CONVERT = 4'h2,
    CMD_PWRDN = 4'h3
  } acfs_cmd_t;

  typedef struct packed {
    logic [15:0] seq;
    logic auto_pd;
    logic [1:0] seq_len_m1;
    logic [2:0] thr_m1;
    acfs_mode_t mode;
  } acfs_cfg_t;

  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [DATA_W-1:0] data;
  } acfs_entry_t;
endpackage

// [acfs_core.sv]
// Conversion mode sequencer with result FIFO and Wishbone registers.
`timescale 1ns/1ps

module acfs_core
  import acfs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link pins, asynchronous to clk_i.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic conversion_start_pin_n_i,
  input wire logic pd_n_i,
  // Converter core.
  input wire logic [acfs_pkg::DATA_W-1:0] adc_data_i,
  output logic [acfs_pkg::CH_W-1:0] ch_sel_o,
  output logic eoc_o,
  output logic powerdown_o,
  output logic irq_o
);
  import acfs_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } acfs_state_t;

  function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [CH_W-1:0] seq_ch(input logic [15:0] seq,
                                             input logic [IDX_W-1:0] idx);
    return seq[idx*CH_W +: CH_W];
  endfunction

  // Pin synchronisers: bit 0 link clock, 1 chip select, 2 start, 3 power down.
  logic [3:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [3:0] nxt_filt;

  always_comb begin
    nxt_filt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 4'hF;
      s2_ff <= 4'hF;
      s3_ff <= 4'hF;
      filt_ff <= 4'hF;
    end else begin
      s1_ff <= {pd_n_i, conversion_start_pin_n_i, cs_n_i, sclk_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Core state.
  acfs_state_t state_ff, nxt_state;
  acfs_cfg_t cfg_ff, nxt_cfg;
  acfs_entry_t fifo_ff [FIFO_DEPTH];
  acfs_entry_t nxt_fifo [FIFO_DEPTH];
  acfs_entry_t sgl_ff, nxt_sgl;
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic [4:0] sclk_cnt_ff, nxt_sclk_cnt;
  logic [CH_W-1:0] sel_ch_ff, nxt_sel_ch, conv_ch_ff, nxt_conv_ch;
  logic hold_ff, nxt_hold, chan_ok_ff, nxt_chan_ok;
  logic sgl_valid_ff, nxt_sgl_valid, sw_pd_ff, nxt_sw_pd;
  logic [IRQ_W-1:0] irq_st_ff, nxt_irq_st, irq_mask_ff, nxt_irq_mask;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;

  // Decoded events, also watched by the checks below.
  logic wb_go, wr_cfg, cmd_wr, trig, pop, push, start, refuse, hw_pd;
  logic sclk_rise, cs_fall, cst_fall;
  acfs_cmd_t cmd_code;
  logic [31:0] wtmp;
  logic [CNT_W-1:0] thr;
  logic [IRQ_W-1:0] ev;
  logic sweep;

  always_comb begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_fifo = fifo_ff;
    nxt_sgl = sgl_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_sclk_cnt = sclk_cnt_ff;
    nxt_sel_ch = sel_ch_ff;
    nxt_conv_ch = conv_ch_ff;
    nxt_hold = hold_ff;
    nxt_chan_ok = chan_ok_ff;
    nxt_sgl_valid = sgl_valid_ff;
    nxt_sw_pd = sw_pd_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_dat = dat_ff;
    ev = '0;
    refuse = 1'b0;
    start = 1'b0;
    push = 1'b0;
    wtmp = 32'h0000_0000;

    sclk_rise = nxt_filt[0] & ~filt_ff[0];
    cs_fall = ~nxt_filt[1] & filt_ff[1];
    cst_fall = ~nxt_filt[2] & filt_ff[2];
    sweep = cfg_ff.mode[1];
    thr = {1'b0, cfg_ff.thr_m1} + 4'h1;

    // The answer is registered, so a request is served one edge after it
    // appears and the bus needs one idle cycle between requests.
    wb_go = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_ack = wb_go;
    wr_cfg = wb_go & wb_we_i & (wb_adr_i == REG_CFG);
    cmd_wr = wb_go & wb_we_i & (wb_adr_i == REG_CMD) & wb_sel_i[0];
    cmd_code = acfs_cmd_t'(wb_dat_i[CMD_CODE_LSB +: 4]);
    pop = wb_go & ~wb_we_i & (wb_adr_i == REG_FIFO) & (cnt_ff != 4'h0);
    trig = cs_fall | cst_fall | (cmd_wr & (cmd_code == CMD_CONVERT));

    // Reads; a FIFO read hands back the oldest entry.
    if (wb_go & ~wb_we_i) begin
      unique case (wb_adr_i)
        REG_CFG: nxt_dat = {8'h00, cfg_ff};
        REG_FIFO: nxt_dat = pop ? {16'h0000, fifo_ff[rd_ptr_ff]} :
                                  32'h0000_0000;
        REG_STATUS: begin
          nxt_dat = 32'h0000_0000;
          nxt_dat[ST_CNT_LSB +: CNT_W] = cnt_ff;
          nxt_dat[ST_HOLD] = hold_ff;
          nxt_dat[ST_BUSY] = (state_ff == ST_CONV);
          nxt_dat[ST_CHAN_OK] = chan_ok_ff;
          nxt_dat[ST_PD] = powerdown_o;
          nxt_dat[ST_SGL_VALID] = sgl_valid_ff;
          nxt_dat[ST_IDX_LSB +: IDX_W] = idx_ff;
          nxt_dat[ST_CH_LSB +: CH_W] = sel_ch_ff;
        end
        REG_SINGLE: begin
          nxt_dat = {16'h0000, sgl_ff};
          nxt_sgl_valid = 1'b0;
        end
        REG_IRQ_ST: nxt_dat = {29'h0, irq_st_ff};
        REG_IRQ_MASK: nxt_dat = {29'h0, irq_mask_ff};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end

    if (pop) begin
      nxt_rd_ptr = rd_ptr_ff + 3'h1;
      nxt_cnt = cnt_ff - 4'h1;
      if (cnt_ff == 4'h1) begin
        // Draining releases the hold; sweeps resume from the first entry.
        nxt_hold = 1'b0;
        nxt_idx = '0;
      end
    end

    if (wb_go & wb_we_i & (wb_adr_i == REG_IRQ_MASK)) begin
      wtmp = apply_sel({29'h0, irq_mask_ff}, wb_dat_i, wb_sel_i);
      nxt_irq_mask = wtmp[IRQ_W-1:0];
    end

    // Select and power down commands are refused while the FIFO is held.
    if (cmd_wr & (cmd_code == CMD_SELECT)) begin
      if (hold_ff) begin
        refuse = 1'b1;
      end else begin
        nxt_sel_ch = wb_dat_i[CMD_CH_LSB +: CH_W];
        nxt_chan_ok = 1'b1;
        nxt_sw_pd = 1'b0;
      end
    end
    if (cmd_wr & (cmd_code == CMD_PWRDN)) begin
      if (hold_ff | (state_ff == ST_CONV)) begin
        refuse = 1'b1;
      end else begin
        nxt_sw_pd = 1'b1;
      end
    end

    // Conversion triggers.
    if (trig) begin
      if ((state_ff == ST_CONV) | hw_pd) begin
        refuse = 1'b1;
      end else if (hold_ff & (cfg_ff.mode == MODE_SWEEP)) begin
        refuse = 1'b1;
      end else if (hold_ff & (cfg_ff.mode == MODE_RSWEEP)) begin
        nxt_cnt = 4'h0;
        nxt_rd_ptr = '0;
        nxt_wr_ptr = '0;
        nxt_idx = '0;
        nxt_hold = 1'b0;
        start = 1'b1;
      end else if (hold_ff) begin
        refuse = 1'b1;
      end else if (~sweep & ~chan_ok_ff) begin
        refuse = 1'b1;
      end else begin
        start = 1'b1;
      end
    end

    if (start) begin
      nxt_state = ST_CONV;
      nxt_sclk_cnt = 5'h00;
      nxt_sw_pd = 1'b0;
      nxt_conv_ch = sweep ? seq_ch(cfg_ff.seq, nxt_idx) : sel_ch_ff;
    end

    // Conversion counts link clock edges, then lands its result.
    if (state_ff == ST_CONV & sclk_rise) begin
      if (sclk_cnt_ff == CONV_SCLKS - 5'h01) begin
        nxt_state = ST_IDLE;
        ev[IRQ_DONE] = 1'b1;
        if (cfg_ff.mode == MODE_SINGLE) begin
          nxt_sgl = '{ch: conv_ch_ff, data: adc_data_i};
          nxt_sgl_valid = 1'b1;
        end else begin
          push = 1'b1;
        end
      end else begin
        nxt_sclk_cnt = sclk_cnt_ff + 5'h01;
      end
    end

    if (push) begin
      nxt_fifo[wr_ptr_ff] = '{ch: conv_ch_ff, data: adc_data_i};
      nxt_wr_ptr = wr_ptr_ff + 3'h1;
      nxt_cnt = nxt_cnt + 4'h1;
      nxt_idx = (idx_ff == cfg_ff.seq_len_m1) ? '0 : idx_ff + 2'h1;
      if (nxt_cnt == thr) begin
        nxt_hold = 1'b1;
        nxt_idx = '0;
        ev[IRQ_THR] = 1'b1;
      end
    end

    // A configuration write discards the FIFO and any channel selection.
    if (wr_cfg) begin
      wtmp = apply_sel({8'h00, cfg_ff}, wb_dat_i, wb_sel_i);
      nxt_cfg = acfs_cfg_t'(wtmp[23:0]);
      nxt_state = ST_IDLE;
      nxt_cnt = 4'h0;
      nxt_rd_ptr = '0;
      nxt_wr_ptr = '0;
      nxt_idx = '0;
      nxt_hold = 1'b0;
      nxt_chan_ok = 1'b0;
      nxt_sgl_valid = 1'b0;
    end

    ev[IRQ_REFUSE] = refuse;
    // A new event wins over a clear in the same cycle.
    if (wb_go & wb_we_i & (wb_adr_i == REG_IRQ_ST)) begin
      wtmp = apply_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
    end
    nxt_irq_st = (irq_st_ff & ~wtmp[IRQ_W-1:0]) | ev;
    if (wr_cfg | (wb_go & wb_we_i & (wb_adr_i == REG_IRQ_MASK))) begin
      nxt_irq_st = irq_st_ff | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cfg_ff <= acfs_cfg_t'(CFG_RST);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_ff[i] <= '0;
      end
      sgl_ff <= '0;
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      idx_ff <= '0;
      sclk_cnt_ff <= '0;
      sel_ch_ff <= '0;
      conv_ch_ff <= '0;
      hold_ff <= 1'b0;
      chan_ok_ff <= 1'b0;
      sgl_valid_ff <= 1'b0;
      sw_pd_ff <= 1'b0;
      irq_st_ff <= '0;
      irq_mask_ff <= '0;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      fifo_ff <= nxt_fifo;
      sgl_ff <= nxt_sgl;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      sclk_cnt_ff <= nxt_sclk_cnt;
      sel_ch_ff <= nxt_sel_ch;
      conv_ch_ff <= nxt_conv_ch;
      hold_ff <= nxt_hold;
      chan_ok_ff <= nxt_chan_ok;
      sgl_valid_ff <= nxt_sgl_valid;
      sw_pd_ff <= nxt_sw_pd;
      irq_st_ff <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign ch_sel_o = conv_ch_ff;
  // Kept outside the next-state process: the status read uses powerdown_o.
  assign hw_pd = ~filt_ff[3];
  assign eoc_o = (state_ff == ST_IDLE);
  // Auto power down idles the converter between conversions at no cost.
  assign powerdown_o = sw_pd_ff | hw_pd |
                       (cfg_ff.auto_pd & (state_ff == ST_IDLE));
  assign irq_o = |(irq_st_ff & irq_mask_ff);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_sweep_stop_seq: assert property (
    hold_ff && cfg_ff.mode == MODE_SWEEP && !wr_cfg |=> state_ff == ST_IDLE)
    else $error("sweep started a conversion while holding");
  chk_hold_cmd_only: assert property (
    hold_ff && cmd_wr && cmd_code == CMD_SELECT
    |=> irq_st_ff[IRQ_REFUSE] && sel_ch_ff == $past(sel_ch_ff))
    else $error("command executed while FIFO held");
  chk_sweep_conv_drop: assert property (
    hold_ff && cfg_ff.mode == MODE_SWEEP && trig && !wr_cfg && !pop
    |=> $stable(cnt_ff) && hold_ff)
    else $error("sweep conversion command was not dropped");
  chk_rsweep_restart: assert property (
    hold_ff && cfg_ff.mode == MODE_RSWEEP && trig && !wr_cfg && !hw_pd
    && state_ff == ST_IDLE
    |=> cnt_ff == 4'h0 && state_ff == ST_CONV
    && conv_ch_ff == cfg_ff.seq[3:0])
    else $error("repeat sweep did not flush and restart");
  chk_drain_release: assert property (
    hold_ff && pop && cnt_ff == 4'h1 |=> !hold_ff ##1 !hold_ff)
    else $error("hold not released after drain");
  chk_single_bypass: assert property (
    push |-> cfg_ff.mode != MODE_SINGLE)
    else $error("single shot result went to FIFO");
  chk_fifo_order: assert property (
    pop |=> wb_ack_o && wb_dat_o[15:0] == $past(fifo_ff[rd_ptr_ff]))
    else $error("FIFO read out of order");
  chk_thr_hold: assert property (
    push && !pop && !wr_cfg && cnt_ff + 4'h1 == thr
    |=> hold_ff && cnt_ff == thr)
    else $error("threshold reached without hold");
  chk_seq_retain: assert property (
    sweep && pop && cnt_ff == 4'h1 && !wr_cfg
    |=> idx_ff == '0 && $stable(cfg_ff))
    else $error("sweep setup lost after drain");
  chk_swpd_cmd: assert property (
    cmd_wr && cmd_code == CMD_PWRDN && !hold_ff && state_ff == ST_IDLE
    && !trig |=> powerdown_o)
    else $error("software power down not entered");
  chk_trig_start: assert property (
    start && !wr_cfg |=> state_ff == ST_CONV && !eoc_o)
    else $error("trigger did not start conversion");
endmodule

// [acfs_link_model.sv]
// Behavioural host link model that drives the conversion pins.
`timescale 1ns/1ps
module acfs_link_model
  import acfs_pkg::*;
(
  // Link pins.
  output logic sclk_o,
  output logic cs_n_o,
  output logic start_n_o,
  // Converter result.
  output logic [acfs_pkg::DATA_W-1:0] data_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    start_n_o = 1'b1;
    data_o = '0;
  end

  // The clock only runs inside a frame, as a real host port does.
  task automatic frame(input int trig, input logic [DATA_W-1:0] d);
    // A frame opens on a clock edge, so its pins move by non-blocking drive.
    data_o <= d;
    cs_n_o <= (trig != 1);
    start_n_o <= (trig != 2);
    #100;
    repeat (16) begin
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    cs_n_o = 1'b1;
    start_n_o = 1'b1;
    // Past the hold time the result lines no longer carry the value.
    data_o = ~d;
  endtask
endmodule

// [acfs_core_test.sv]
// Self-checking bench of the conversion sequencer with a queue model.
`timescale 1ns/1ps
module acfs_core_test;
  import acfs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic pd_n = 1'b1;
  logic sclk;
  logic cs_n;
  logic start_n;
  logic [DATA_W-1:0] adc;
  logic [31:0] rdo;
  logic [31:0] rdat;
  logic [CH_W-1:0] ch_sel;
  logic eoc;
  logic pwd;
  logic irq;
  logic ack;
  logic [31:0] lf = 32'h00010D2E;
  logic [15:0] mq[$];
  logic [15:0] single_exp;
  int n_errors = 0;
  int n_compared = 0;

  acfs_core acfs_core_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'hF),
    .wb_dat_i(wdat),
    .wb_dat_o(rdo),
    .wb_ack_o(ack),
    .sclk_i(sclk),
    .cs_n_i(cs_n),
    .conversion_start_pin_n_i(start_n),
    .pd_n_i(pd_n),
    .adc_data_i(adc),
    .ch_sel_o(ch_sel),
    .eoc_o(eoc),
    .powerdown_o(pwd),
    .irq_o(irq)
  );

  acfs_link_model acfs_link_model_i (
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .start_n_o(start_n),
    .data_o(adc)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  localparam int PIN_EOC = 0;
  localparam int PIN_IRQ = 1;
  localparam int PIN_PWD = 2;

  // Pins are looked at two cycles on, once registered updates have landed.
  // The pin is named by number so that its late value is the one compared.
  task automatic check_pin(input int pin, input logic exp);
    logic got;
    repeat (2) @(posedge clk_i);
    got = (pin == PIN_EOC) ? eoc : (pin == PIN_IRQ) ? irq : pwd;
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) n_errors++;
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    check(rdat & m, exp);
  endtask

  task automatic drain(input int n);
    repeat (n) begin
      wb(1'b0, REG_FIFO, 32'h00000000);
      check(rdat, {16'h0000, mq.pop_front()});
    end
  endtask

  // Trigger 0 is the command register, 1 chip select, 2 the start pin.
  task automatic conv(input int trig, input int keep, input logic [3:0] ch);
    logic [DATA_W-1:0] d;
    lf = lfsr(lf);
    d = lf[DATA_W-1:0];
    if (trig == 0) wr(REG_CMD, 32'h00000002);
    acfs_link_model_i.frame(trig, d);
    check_pin(PIN_EOC, 1'b1);
    if (keep == 1) mq.push_back({ch, d});
    if (keep == 2) single_exp = {ch, d};
    if (keep != 0) check({28'h0000000, ch_sel}, {28'h0000000, ch});
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdm(REG_CFG, 32'hFFFFFFFF, {8'h00, CFG_RST});
    rdm(REG_IRQ_MASK, 32'hFFFFFFFF, 32'h00000000);
    rdm(8'h1C, 32'hFFFFFFFF, 32'h00000000);
    $display("test reset finished");
    wr(REG_IRQ_MASK, 32'h00000004);
    wr(REG_CFG, 32'h0000000D);
    conv(1, 0, 4'h0);
    check_pin(PIN_IRQ, 1'b1);
    wr(REG_IRQ_ST, 32'h00000004);
    check_pin(PIN_IRQ, 1'b0);
    wr(REG_CMD, 32'h00000051);
    for (int i = 0; i < 4; i++) begin
      conv(i % 2 + 1, 1, 4'h5);
    end
    conv(1, 0, 4'h0);
    rdm(REG_STATUS, 32'h0000001F, 32'h00000014);
    drain(4);
    wr(REG_CMD, 32'h00000051);
    conv(2, 1, 4'h5);
    drain(1);
    rdm(REG_IRQ_ST, 32'hFFFFFFFF, 32'h00000007);
    wr(REG_IRQ_ST, 32'h00000007);
    rdm(REG_IRQ_ST, 32'hFFFFFFFF, 32'h00000000);
    $display("test repeat finished");
    wr(REG_CFG, 32'h00000000);
    wr(REG_CMD, 32'h00000031);
    conv(0, 2, 4'h3);
    rdm(REG_SINGLE, 32'h0000FFFF, {16'h0000, single_exp});
    rdm(REG_STATUS, 32'h0000000F, 32'h00000000);
    $display("test single finished");
    wr(REG_CFG, 32'h0043216E);
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 4; k++) begin
        conv(k % 2 + 1, 1, 4'(k + 1));
      end
      conv(0, 0, 4'h0);
      // A select while held is refused, so channel 3 stays selected.
      wr(REG_CMD, 32'h00000061);
      rdm(REG_STATUS, 32'h0000F01F, 32'h00003014);
      rdm(REG_CFG, 32'hFFFFFFFF, 32'h0043216E);
      drain(4);
    end
    $display("test sweep finished");
    wr(REG_CFG, 32'h0043216F);
    for (int k = 0; k < 4; k++) begin
      conv(2 - k % 2, 1, 4'(k + 1));
    end
    mq.delete();
    conv(0, 1, 4'h1);
    rdm(REG_STATUS, 32'h0000001F, 32'h00000001);
    drain(1);
    // Emptying the FIFO sends the sweep back to its first entry.
    conv(1, 1, 4'h1);
    wr(REG_CFG, 32'h0043216F);
    mq.delete();
    rdm(REG_STATUS, 32'h0000000F, 32'h00000000);
    $display("test repeat sweep finished");
    wr(REG_CFG, 32'h00000000);
    wr(REG_CMD, 32'h00000003);
    check_pin(PIN_PWD, 1'b1);
    wr(REG_CMD, 32'h00000011);
    check_pin(PIN_PWD, 1'b0);
    wr(REG_CFG, 32'h00000080);
    check_pin(PIN_PWD, 1'b1);
    wr(REG_CFG, 32'h00000000);
    check_pin(PIN_PWD, 1'b0);
    pd_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    check_pin(PIN_PWD, 1'b1);
    pd_n <= 1'b1;
    $display("test power down finished");
    end_sim;
  end

  // The run needs about 65 us; nine times that means a hang.
  initial begin
    #600000;
    n_errors++;
    end_sim;
  end
endmodule
